// ### rtl/psm_pkg.sv
// package: constants and types for the power supply management target
package psm_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int STRETCH_MAX_MS = 25;
   localparam int STUCK_MS = 35;
   localparam int OTW_WARN_S = 10;
   localparam int STRETCH_CYC = (STRETCH_MAX_MS * (CLK_HZ / 1000));
   localparam int STUCK_CYC = (STUCK_MS * (CLK_HZ / 1000)) + 1;
   localparam longint OTW_CYC = longint'(OTW_WARN_S) * CLK_HZ;
   localparam logic [3:0] SUPERVISOR_HI = 4'h_b;
   localparam logic [3:0] MEMORY_HI = 4'h_a;
   localparam logic [7:0] BCAST_ADDR = 8'h_00;
   localparam logic [7:0] VENDOR_LO = 8'h_d0;
   localparam logic [7:0] VENDOR_HI = 8'h_ef;
   localparam logic [7:0] CRC_POLY = 8'h_07;
   localparam logic [7:0] CMD_OPERATION = 8'h_01;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h_03;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h_79;
   localparam logic [7:0] CMD_VOUT = 8'h_21;
   localparam int OP_ON_BIT = 7;
   localparam logic [7:0] OP_RESET = 8'h_80;
   localparam logic [15:0] VOUT_RESET = 16'h_0000;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_ADDR = 6'b00_0010,
      ST_WACK = 6'b00_0100,
      ST_RX = 6'b00_1000,
      ST_TX = 6'b01_0000,
      ST_RACK = 6'b10_0000
   } psm_state_type;

   typedef struct packed {
      logic over_temp;
      logic over_voltage_trip;
      logic over_current_trip;
      logic input_fault;
      logic input_good_raw;
      logic output_present;
   } psm_health_type;

   typedef struct packed {
      logic valid;
      logic broadcast;
      logic memory;
      logic [7:0] cmd;
      logic [15:0] data;
      logic [1:0] count;
   } psm_write_type;
endpackage

// ### rtl/psm_slave.sv
// power supply management target: serial bus link and status outputs
`timescale 1ns/1ns
module psm_slave
   import psm_pkg::*;
#(
   parameter int STRETCH_CYCLES = STRETCH_CYC,
   parameter int STUCK_CYCLES = STUCK_CYC,
   parameter longint OTW_CYCLES = OTW_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic bus_clk,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic module_select_bit_2,
   input wire logic module_select_bit_1,
   input wire logic module_select_bit_0,
   input wire logic write_protect,
   input wire logic analog_prog_valid,
   input wire logic remote_off,
   input wire logic enable_open,
   input wire logic busy,
   input wire psm_health_type health,
   output logic main_on,
   output logic [15:0] setpoint,
   output logic setpoint_from_bus,
   output logic mem_write,
   output logic [7:0] mem_cmd,
   output logic [15:0] mem_data,
   output logic vendor_cmd,
   output logic input_good,
   output logic output_good,
   output logic over_temp_warn_n,
   output logic fault_n,
   output logic alert_n
);
   function automatic logic [7:0] crc_step(input logic [7:0] c,
                                           input logic b);
      logic fb;
      fb = c[7] ^ b;
      crc_step = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h_00);
   endfunction

   // ---------------- link domain (bus_clk samples the bus) ----------------
   logic [2:0] scl_sync_reg, sda_sync_reg;
   logic [2:0] sel;
   assign sel = {module_select_bit_2, module_select_bit_1,
                 module_select_bit_0};
   always_ff @(posedge bus_clk or negedge resetn) begin
      if (!resetn) begin
         scl_sync_reg <= 3'b111;
         sda_sync_reg <= 3'b111;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      end
   end
   logic scl_reg, sda_reg, scl_prev_reg, sda_prev_reg;
   always_ff @(posedge bus_clk or negedge resetn) begin
      if (!resetn) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         if (scl_sync_reg[1] == scl_sync_reg[2]) scl_reg <= scl_sync_reg[2];
         if (sda_sync_reg[1] == sda_sync_reg[2]) sda_reg <= sda_sync_reg[2];
         scl_prev_reg <= scl_reg;
         sda_prev_reg <= sda_reg;
      end
   end
   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_reg & ~scl_prev_reg;
   assign scl_fall = ~scl_reg & scl_prev_reg;
   assign start_det = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
   assign stop_det = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;

   // bus stuck detector
   logic [31:0] low_cnt_reg;
   logic stuck;
   always_ff @(posedge bus_clk or negedge resetn) begin
      if (!resetn) low_cnt_reg <= '0;
      else if (scl_reg && sda_reg) low_cnt_reg <= '0;
      else if (!stuck) low_cnt_reg <= low_cnt_reg + 32'd1;
   end
   assign stuck = (low_cnt_reg >= 32'(STUCK_CYCLES));

   // busy level and status flags cross into the link domain
   logic busy_s1_reg, busy_s2_reg;
   logic [15:0] status_word, st_s1_reg, st_s2_reg;
   always_ff @(posedge bus_clk or negedge resetn) begin
      if (!resetn) begin
         busy_s1_reg <= 1'b0;
         busy_s2_reg <= 1'b0;
         st_s1_reg <= 16'h_0000;
         st_s2_reg <= 16'h_0000;
      end else begin
         busy_s1_reg <= busy;
         busy_s2_reg <= busy_s1_reg;
         st_s1_reg <= status_word;
         st_s2_reg <= st_s1_reg;
      end
   end

   psm_state_type state_reg;
   logic [7:0] shift_reg, crc_reg, tx_reg;
   logic [3:0] bit_reg;
   logic rw_reg, bcast_reg, mem_reg, first_reg, hold_reg;
   logic [1:0] cnt_reg;
   logic [7:0] cmd_reg;
   logic [15:0] data_reg;
   logic [31:0] str_cnt_reg;
   logic wr_toggle_reg, ack_drive_reg;
   psm_write_type wr_reg;
   logic [1:0] rd_idx_reg;
   logic rd_status_toggle_reg;
   logic addr_hit;
   always_comb begin
      addr_hit = 1'b0;
      if (shift_reg == BCAST_ADDR) addr_hit = 1'b1;
      if (shift_reg[7:1] == {SUPERVISOR_HI, sel}) addr_hit = 1'b1;
      if (shift_reg[7:1] == {MEMORY_HI, sel}) addr_hit = 1'b1;
   end

   always_ff @(posedge bus_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         shift_reg <= 8'h_00;
         bit_reg <= 4'h_0;
         rw_reg <= 1'b0;
         bcast_reg <= 1'b0;
         mem_reg <= 1'b0;
         first_reg <= 1'b0;
         cnt_reg <= 2'b00;
         cmd_reg <= 8'h_00;
         data_reg <= 16'h_0000;
         crc_reg <= 8'h_00;
         tx_reg <= 8'h_ff;
         ack_drive_reg <= 1'b0;
         wr_toggle_reg <= 1'b0;
         wr_reg <= '0;
         rd_idx_reg <= 2'b00;
         rd_status_toggle_reg <= 1'b0;
      end else if (stuck) begin
         state_reg <= ST_IDLE;
         ack_drive_reg <= 1'b0;
      end else if (start_det) begin
         state_reg <= ST_ADDR;
         bit_reg <= 4'h_0;
         ack_drive_reg <= 1'b0;
         crc_reg <= (state_reg == ST_IDLE) ? 8'h_00 : crc_reg;
      end else if (stop_det) begin
         state_reg <= ST_IDLE;
         ack_drive_reg <= 1'b0;
         if (cnt_reg != 2'b00 || first_reg) begin
            wr_reg <= '{valid: 1'b1, broadcast: bcast_reg, memory: mem_reg,
                        cmd: cmd_reg, data: data_reg, count: cnt_reg};
            wr_toggle_reg <= ~wr_toggle_reg;
         end
         first_reg <= 1'b0;
         cnt_reg <= 2'b00;
      end else begin
         unique case (state_reg)
            ST_IDLE: ;
            ST_ADDR, ST_RX: if (scl_rise) begin
               shift_reg <= {shift_reg[6:0], sda_reg};
               bit_reg <= bit_reg + 4'h_1;
            end else if (scl_fall && bit_reg != 4'h_8) begin
               // a bit counts once scl falls; start or stop drops it
               if (bit_reg != 4'h_0)
                  crc_reg <= crc_step(crc_reg, shift_reg[0]);
            end else if (scl_fall) begin
               crc_reg <= crc_step(crc_reg, shift_reg[0]);
               bit_reg <= 4'h_0;
               if (state_reg == ST_ADDR) begin
                  rw_reg <= shift_reg[0];
                  bcast_reg <= (shift_reg == BCAST_ADDR);
                  mem_reg <= (shift_reg[7:4] == MEMORY_HI);
                  ack_drive_reg <= addr_hit;
                  state_reg <= addr_hit ? ST_WACK : ST_IDLE;
                  rd_idx_reg <= 2'b00;
                  tx_reg <= st_s2_reg[7:0];
               end else begin
                  ack_drive_reg <= 1'b1;
                  state_reg <= ST_WACK;
                  if (!first_reg) begin
                     cmd_reg <= shift_reg;
                     first_reg <= 1'b1;
                     cnt_reg <= 2'b00;
                  end else if (cnt_reg == 2'b00) begin
                     data_reg[7:0] <= shift_reg;
                     cnt_reg <= 2'b01;
                  end else if (cnt_reg == 2'b01) begin
                     data_reg[15:8] <= shift_reg;
                     cnt_reg <= 2'b10;
                  end else begin
                     cnt_reg <= 2'b11; // trailing check byte
                  end
               end
            end
            ST_WACK: if (scl_fall) begin
               ack_drive_reg <= 1'b0;
               // reads never served through broadcast
               if (rw_reg && !bcast_reg && bit_reg == 4'h_0) begin
                  state_reg <= ST_TX;
                  rw_reg <= 1'b0;
                  if (cmd_reg == CMD_STATUS_WORD)
                     rd_status_toggle_reg <= ~rd_status_toggle_reg;
               end else if (rw_reg) state_reg <= ST_IDLE;
               else state_reg <= ST_RX;
            end
            ST_TX: if (scl_fall) begin
               if (bit_reg == 4'h_7) begin
                  bit_reg <= 4'h_0;
                  state_reg <= ST_RACK;
               end else begin
                  tx_reg <= {tx_reg[6:0], 1'b1};
                  bit_reg <= bit_reg + 4'h_1;
               end
            end else if (scl_rise) crc_reg <= crc_step(crc_reg, tx_reg[7]);
            ST_RACK: if (scl_rise) begin
               state_reg <= sda_reg ? ST_IDLE : ST_RACK;
               rd_idx_reg <= rd_idx_reg + 2'b01;
            end else if (scl_fall) begin
               state_reg <= ST_TX;
               tx_reg <= (rd_idx_reg == 2'b01) ? st_s2_reg[15:8] :
                         crc_reg;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // stretch after the ack bit only, bounded
   always_ff @(posedge bus_clk or negedge resetn) begin
      if (!resetn) begin
         hold_reg <= 1'b0;
         str_cnt_reg <= '0;
      end else if (hold_reg) begin
         str_cnt_reg <= str_cnt_reg + 32'd1;
         if (!busy_s2_reg || str_cnt_reg >= 32'(STRETCH_CYCLES - 1) || stuck)
            hold_reg <= 1'b0;
      end else begin
         str_cnt_reg <= '0;
         if (state_reg == ST_WACK && scl_fall && busy_s2_reg)
            hold_reg <= 1'b1;
      end
   end
   // output enable low while driving low; data pins drive only zeros
   assign scl_out = 1'b0;
   assign scl_oe = ~hold_reg;
   assign sda_out = 1'b0;
   assign sda_oe = ~((ack_drive_reg) ||
                     (state_reg == ST_TX && !tx_reg[7]));

   // ---------------- crossings into ref_clk ----------------
   logic [2:0] wr_tg_sync_reg, rs_tg_sync_reg;
   psm_write_type wr_cap_reg;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_tg_sync_reg <= 3'b000;
         rs_tg_sync_reg <= 3'b000;
      end else begin
         wr_tg_sync_reg <= {wr_tg_sync_reg[1:0], wr_toggle_reg};
         rs_tg_sync_reg <= {rs_tg_sync_reg[1:0], rd_status_toggle_reg};
      end
   end
   logic wr_evt, rs_evt;
   assign wr_evt = wr_tg_sync_reg[2] ^ wr_tg_sync_reg[1];
   assign rs_evt = rs_tg_sync_reg[2] ^ rs_tg_sync_reg[1];

   logic [7:0] operation_reg;
   logic [15:0] vout_reg;
   logic clear_req;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         operation_reg <= OP_RESET;
         vout_reg <= VOUT_RESET;
         mem_write <= 1'b0;
         mem_cmd <= 8'h_00;
         mem_data <= 16'h_0000;
         vendor_cmd <= 1'b0;
         clear_req <= 1'b0;
         wr_cap_reg <= '0;
      end else begin
         mem_write <= 1'b0;
         vendor_cmd <= 1'b0;
         clear_req <= 1'b0;
         if (wr_evt) begin
            wr_cap_reg <= wr_reg;
            if (wr_reg.memory) begin
               mem_write <= ~write_protect;
               mem_cmd <= wr_reg.cmd;
               mem_data <= wr_reg.data;
            end else begin
               if (wr_reg.cmd >= VENDOR_LO && wr_reg.cmd <= VENDOR_HI)
                  vendor_cmd <= 1'b1;
               if (wr_reg.cmd == CMD_OPERATION && wr_reg.count != 2'b00)
                  operation_reg <= wr_reg.data[7:0];
               if (wr_reg.cmd == CMD_VOUT && wr_reg.count[1])
                  vout_reg <= wr_reg.data;
               if (wr_reg.cmd == CMD_CLEAR_FAULTS) clear_req <= 1'b1;
            end
         end
      end
   end

   // pin inputs through three flops, accepted on agreement
   localparam int NPIN = 9;
   logic [NPIN-1:0] pin_raw, pin_reg;
   logic [NPIN-1:0] p1_reg, p2_reg, p3_reg;
   assign pin_raw = {remote_off, enable_open, analog_prog_valid,
                     health.over_temp, health.over_voltage_trip,
                     health.over_current_trip, health.input_fault,
                     health.input_good_raw, health.output_present};
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         p1_reg <= '0;
         p2_reg <= '0;
         p3_reg <= '0;
         pin_reg <= '0;
      end else begin
         p1_reg <= pin_raw;
         p2_reg <= p1_reg;
         p3_reg <= p2_reg;
         for (int i = 0; i < NPIN; i++)
            if (p2_reg[i] == p3_reg[i]) pin_reg[i] <= p3_reg[i];
      end
   end
   logic f_remote, f_open, f_aprog, f_ot, f_ov, f_oc, f_inf, f_ing, f_out;
   assign {f_remote, f_open, f_aprog, f_ot, f_ov, f_oc, f_inf, f_ing,
           f_out} = pin_reg;

   // over temperature warning, then shutdown
   logic [35:0] otw_cnt_reg;
   logic ot_shut_reg;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         otw_cnt_reg <= '0;
         ot_shut_reg <= 1'b0;
      end else if (!f_ot) begin
         otw_cnt_reg <= '0;
         ot_shut_reg <= 1'b0;
      end else if (otw_cnt_reg >= 36'(OTW_CYCLES - 1)) begin
         ot_shut_reg <= 1'b1;
      end else otw_cnt_reg <= otw_cnt_reg + 36'd1;
   end

   logic on_next;
   assign on_next = operation_reg[OP_ON_BIT] && !f_remote
                    && !f_open && !ot_shut_reg;
   assign status_word = {f_inf, f_ov, f_oc, ~main_on, 3'b000, f_ot,
                         vendor_cmd, 7'b000_0000};
   logic [5:0] cond_reg;
   logic alert_reg, off_seen_reg;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         main_on <= 1'b0;
         setpoint <= 16'h_0000;
         setpoint_from_bus <= 1'b0;
         input_good <= 1'b0;
         output_good <= 1'b0;
         over_temp_warn_n <= 1'b1;
         fault_n <= 1'b1;
         cond_reg <= '0;
         alert_reg <= 1'b0;
         off_seen_reg <= 1'b0;
      end else begin
         main_on <= on_next;
         setpoint_from_bus <= ~f_aprog;
         setpoint <= vout_reg;
         input_good <= f_ing && !f_inf;
         output_good <= f_out && main_on;
         over_temp_warn_n <= ~f_ot;
         fault_n <= ~(ot_shut_reg | f_ov | f_oc | f_inf |
                      (main_on & ~f_out));
         cond_reg <= {f_ot, f_ov, f_oc, f_inf, f_ing, main_on};
         if (!on_next) off_seen_reg <= 1'b1;
         // set wins over clear; persisting condition re-asserts
         if (cond_reg != {f_ot, f_ov, f_oc, f_inf, f_ing, main_on} ||
             ((clear_req || rs_evt) && (f_ot | f_ov | f_oc | f_inf)))
            alert_reg <= 1'b1;
         else if (clear_req || rs_evt || (off_seen_reg && on_next)) begin
            alert_reg <= 1'b0;
            off_seen_reg <= 1'b0;
         end
      end
   end
   assign alert_n = ~alert_reg;
endmodule

// ### test/psm_chk_assertions.sv
// checker: timing properties at the management target ports
`timescale 1ns/1ns
module psm_chk
   import psm_pkg::*;
#(
   parameter int STRETCH_CYCLES = STRETCH_CYC,
   parameter int STUCK_CYCLES = STUCK_CYC,
   parameter longint OTW_CYCLES = OTW_CYC
) (
   input wire logic ref_clk,
   input wire logic bus_clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic write_protect,
   input wire logic analog_prog_valid,
   input wire logic remote_off,
   input wire logic enable_open,
   input wire logic busy,
   input wire psm_health_type health,
   input wire logic main_on,
   input wire logic setpoint_from_bus,
   input wire logic mem_write,
   input wire logic over_temp_warn_n,
   input wire logic fault_n,
   input wire logic input_good,
   input wire logic output_good
);
   int str_cnt;
   int low_cnt;
   longint warn_cnt;
   always_ff @(posedge bus_clk or negedge resetn) begin
      if (!resetn) begin
         str_cnt <= 0;
         low_cnt <= 0;
      end else begin
         str_cnt <= scl_oe ? 0 : str_cnt + 1;
         low_cnt <= (scl_in && sda_in) ? 0 : low_cnt + 1;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         warn_cnt <= 0;
      end else begin
         warn_cnt <= over_temp_warn_n ? 0 : warn_cnt + 1;
      end
   end
   sequence s_hot;
      health.over_temp [*6];
   endsequence
   sequence s_trip;
      (health.over_voltage_trip || health.over_current_trip
         || health.input_fault) [*6];
   endsequence
   sequence s_calm;
      (!health.over_temp && !health.over_voltage_trip
         && !health.over_current_trip && !health.input_fault
         && health.output_present) [*8];
   endsequence
   a_warn_on_heat: assert property (@(posedge ref_clk)
      disable iff (!resetn) s_hot |-> !over_temp_warn_n)
      else $error("warning not driven while hot");
   a_warn_lead_time: assert property (@(posedge ref_clk)
      disable iff (!resetn) $fell(main_on) && !over_temp_warn_n
      && !remote_off && !enable_open |-> warn_cnt >= OTW_CYCLES - 4)
      else $error("shutdown before warning period");
   a_fault_on_trip: assert property (@(posedge ref_clk)
      disable iff (!resetn) s_trip |-> !fault_n)
      else $error("fault not driven on trip");
   a_fault_released: assert property (@(posedge ref_clk)
      disable iff (!resetn) s_calm |-> fault_n)
      else $error("fault driven without cause");
   a_input_good_drop: assert property (@(posedge ref_clk)
      disable iff (!resetn) (!health.input_good_raw) [*6] |-> !input_good)
      else $error("input good high out of range");
   a_output_good_drop: assert property (@(posedge ref_clk)
      disable iff (!resetn) (!health.output_present) [*6] |-> !output_good)
      else $error("output good high without output");
   a_main_gated: assert property (@(posedge ref_clk)
      disable iff (!resetn) (remote_off || enable_open) [*6] |-> !main_on)
      else $error("main output on while gated off");
   a_setpoint_source: assert property (@(posedge ref_clk)
      disable iff (!resetn) analog_prog_valid [*6] |-> !setpoint_from_bus)
      else $error("bus setpoint used over analog");
   a_mem_guard: assert property (@(posedge ref_clk)
      disable iff (!resetn) mem_write |-> !write_protect ##1 !mem_write)
      else $error("memory write while protected");
   a_stretch_limit: assert property (@(posedge bus_clk)
      disable iff (!resetn) str_cnt <= STRETCH_CYCLES)
      else $error("clock stretch too long");
   a_stretch_busy: assert property (@(posedge bus_clk)
      disable iff (!resetn) $fell(scl_oe) |-> busy)
      else $error("clock stretch while not busy");
   a_stuck_release: assert property (@(posedge bus_clk)
      disable iff (!resetn) low_cnt > STUCK_CYCLES + 16 |-> sda_oe && scl_oe)
      else $error("bus lines held after lock-up");
endmodule
bind psm_slave psm_chk #(.STRETCH_CYCLES(STRETCH_CYCLES),
   .STUCK_CYCLES(STUCK_CYCLES), .OTW_CYCLES(OTW_CYCLES)) u_chk (
   .ref_clk, .bus_clk, .resetn, .scl_in, .sda_in, .scl_oe, .sda_oe,
   .write_protect, .analog_prog_valid, .remote_off, .enable_open, .busy,
   .health, .main_on, .setpoint_from_bus, .mem_write, .over_temp_warn_n,
   .fault_n, .input_good, .output_good);

// ### test/psm_host.sv
// host model: bus master making the clock, honouring stretch
`timescale 1ns/1ns
module psm_host (
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_rel,
   output logic sda_rel
);
   int half = 1250;
   int max_wait = 0;
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic clk_hi();
      int n;
      n = 0;
      scl_rel = 1'b1;
      #1;
      while (scl_in !== 1'b1 && n < 100000) begin
         #12;
         n++;
      end
      if (n > max_wait) begin
         max_wait = n;
      end
      #(half);
   endtask
   task automatic start();
      #(half / 2);
      sda_rel = 1'b1;
      #(half / 2);
      clk_hi();
      sda_rel = 1'b0;
      #(half);
      scl_rel = 1'b0;
   endtask
   task automatic stop();
      #(half / 2);
      sda_rel = 1'b0;
      #(half / 2);
      clk_hi();
      sda_rel = 1'b1;
      #(half);
   endtask
   task automatic xfer(input logic b, output logic s);
      #(half / 2);
      sda_rel = b;
      #(half / 2);
      clk_hi();
      s = sda_in;
      scl_rel = 1'b0;
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer(d[i], s);
      end
      xfer(1'b1, s);
      ack = !s;
   endtask
   task automatic rd(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer(1'b1, s);
         d[i] = s;
      end
      xfer(last, s);
   endtask
endmodule

// ### test/testbench.sv
// testbench: management target driven through the host model
`timescale 1ns/1ns
module testbench;
   import psm_pkg::*;
   localparam int STR = 2000;
   localparam int STK = 20000;
   localparam int OTW = 50;
   localparam logic [7:0] SUP = 8'h_be;
   localparam logic [7:0] MEM = 8'h_ae;
   logic ref_clk = 1'b0;
   logic bus_clk = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] sel = 3'h_7;
   logic write_protect = 1'b1;
   logic analog_prog_valid = 1'b1;
   logic remote_off = 1'b0;
   logic enable_open = 1'b0;
   logic busy = 1'b0;
   psm_health_type health = 6'h_03;
   wire logic scl_in;
   wire logic sda_in;
   logic h_scl, h_sda, scl_oe, sda_oe, main_on, setpoint_from_bus;
   logic mem_write, vendor_cmd, input_good, output_good;
   logic over_temp_warn_n, fault_n, alert_n;
   logic [7:0] mem_cmd, cap_cmd;
   logic [15:0] setpoint, mem_data, cap_data;
   int n_fail = 0, check_count = 0, n_memw = 0, n_vend = 0, cyc = 0;
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      #7;
      forever #6 bus_clk = ~bus_clk;
   end
   psm_slave #(.STRETCH_CYCLES(STR), .STUCK_CYCLES(STK),
      .OTW_CYCLES(OTW)) DUT (.ref_clk, .resetn, .bus_clk, .scl_in,
      .scl_out(), .scl_oe, .sda_in, .sda_out(), .sda_oe,
      .module_select_bit_2(sel[2]), .module_select_bit_1(sel[1]),
      .module_select_bit_0(sel[0]), .write_protect, .analog_prog_valid,
      .remote_off, .enable_open, .busy, .health, .main_on, .setpoint,
      .setpoint_from_bus, .mem_write, .mem_cmd, .mem_data, .vendor_cmd,
      .input_good, .output_good, .over_temp_warn_n, .fault_n, .alert_n);
   psm_host host (.scl_in, .sda_in, .scl_rel(h_scl), .sda_rel(h_sda));
   assign scl_in = h_scl & scl_oe;
   assign sda_in = h_sda & sda_oe;
   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (mem_write === 1'b1) begin
         n_memw++;
         cap_cmd = mem_cmd;
         cap_data = mem_data;
      end
      if (vendor_cmd === 1'b1) begin
         n_vend++;
      end
      if (cyc == 90000) begin
         n_fail++;
         finish_test();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic probe(input logic [7:0] a, input logic e);
      logic k;
      host.start();
      host.wr(a, k);
      host.stop();
      check(k, e);
   endtask
   task automatic wr_txn(input logic [7:0] a, input logic [7:0] c,
      input logic [15:0] d, input int n);
      logic k;
      host.start();
      host.wr(a, k);
      host.wr(c, k);
      for (int i = 0; i < n; i++) begin
         host.wr(d[8*i +: 8], k);
      end
      host.stop();
      tick(8);
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] c,
      input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? {r[6:0], 1'b0} ^ 8'h_07 : {r[6:0], 1'b0};
      end
      return r;
   endfunction
   initial begin
      logic k;
      logic [7:0] b0, b1, pc, cr;
      logic [7:0] vc [4];
      logic [5:0] hp [5];
      logic [2:0] he [5];
      int v;
      vc = '{8'h_cf, 8'h_d0, 8'h_ef, 8'h_f0};
      hp = '{6'h_13, 6'h_0b, 6'h_07, 6'h_02, 6'h_01};
      he = '{3'h_3, 3'h_3, 3'h_1, 3'h_2, 3'h_5};
      tick(10);
      check({over_temp_warn_n, fault_n, alert_n}, 3'h_7);
      check({input_good, main_on, scl_oe, sda_oe}, 4'h_3);
      tick(10);
      resetn <= 1'b1;
      tick(20);
      check(main_on, 1'b1);
      for (int s = 0; s < 8; s++) begin
         sel <= s[2:0];
         tick(4);
         probe({SUPERVISOR_HI, s[2:0], 1'b0}, 1'b1);
         probe({MEMORY_HI, s[2:0], 1'b0}, 1'b1);
         probe({SUPERVISOR_HI, ~s[2:0], 1'b0}, 1'b0);
      end
      probe(8'h_ce, 1'b0);
      wr_txn(SUP, CMD_OPERATION, 16'h_0000, 1);
      check({main_on, alert_n}, 2'h_0);
      wr_txn(SUP, CMD_CLEAR_FAULTS, 16'h_0000, 0);
      check(alert_n, 1'b1);
      wr_txn(BCAST_ADDR, CMD_OPERATION, 16'h_0080, 1);
      check(main_on, 1'b1);
      host.start();
      host.wr(BCAST_ADDR | 8'h_01, k);
      host.rd(1'b1, b0);
      host.stop();
      check({k, b0}, 9'h_0ff);
      v = n_vend;
      foreach (vc[i]) begin
         wr_txn(SUP, vc[i], 16'h_0000, 0);
      end
      check(n_vend - v, 16'h_0002);
      wr_txn(MEM, 8'h_12, 16'h_a55a, 2);
      check(n_memw, 16'h_0000);
      write_protect <= 1'b0;
      wr_txn(MEM, 8'h_12, 16'h_a55a, 2);
      check(n_memw, 16'h_0001);
      check({cap_cmd, cap_data}, 24'h_12_a55a);
      analog_prog_valid <= 1'b0;
      host.half = 5000;
      wr_txn(SUP, CMD_VOUT, 16'h_1234, 2);
      host.half = 1250;
      check(setpoint, 16'h_1234);
      check(setpoint_from_bus, 1'b1);
      analog_prog_valid <= 1'b1;
      tick(6);
      check(setpoint_from_bus, 1'b0);
      remote_off <= 1'b1;
      tick(10);
      check({main_on, alert_n}, 2'h_0);
      remote_off <= 1'b0;
      enable_open <= 1'b1;
      tick(10);
      check(main_on, 1'b0);
      enable_open <= 1'b0;
      tick(10);
      check(main_on, 1'b1);
      host.start();
      host.wr(SUP, k);
      host.wr(CMD_STATUS_WORD, k);
      host.start();
      host.wr(SUP | 8'h_01, k);
      host.rd(1'b0, b0);
      host.rd(1'b0, b1);
      host.rd(1'b1, pc);
      host.stop();
      tick(8);
      cr = crc8(crc8(8'h_00, SUP), CMD_STATUS_WORD);
      cr = crc8(crc8(crc8(cr, SUP | 8'h_01), b0), b1);
      check(pc, cr);
      check(alert_n, 1'b1);
      health <= 6'h_23;
      tick(10);
      check({over_temp_warn_n, main_on}, 2'h_1);
      tick(OTW);
      check(main_on, 1'b0);
      health <= 6'h_03;
      tick(10);
      check({over_temp_warn_n, main_on}, 2'h_3);
      foreach (hp[i]) begin
         health <= hp[i];
         tick(8);
         check({fault_n, input_good, output_good}, he[i]);
      end
      health <= 6'h_03;
      tick(8);
      check({fault_n, input_good, output_good}, 3'h_7);
      host.max_wait = 0;
      busy <= 1'b1;
      wr_txn(SUP, CMD_CLEAR_FAULTS, 16'h_0000, 0);
      busy <= 1'b0;
      check(host.max_wait > 0, 1'b1);
      check(host.max_wait <= STR + 8, 1'b1);
      host.start();
      for (int i = 7; i >= 0; i--) begin
         host.xfer(SUP[i], k);
      end
      tick(3000);
      check({sda_oe, scl_oe}, 2'h_3);
      host.stop();
      probe(SUP, 1'b1);
      finish_test();
   end
endmodule
